// [verilog/rwsup_map.svh]
// Offsets, field positions, reset values and timing figures of the
// reset and watchdog supervisor. Assumes a 100 MHz core clock.
`ifndef RWSUP_MAP_SVH
`define RWSUP_MAP_SVH
// ----------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------
`define RWS_OFS_WDCFG    8'h00
`define RWS_OFS_MODE     8'h04
`define RWS_OFS_CFG      8'h08
`define RWS_OFS_STAT     8'h0c
// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define RWS_WD_PER_LSB  5
`define RWS_WINDOW_MODE_SELECT_BIT  4
`define RWS_MODE_SRP    2
`define RWS_CFG_STOPOFF 2
`define RWS_STAT_ERR    2
`define RWS_STAT_LOW    3
// ----------------------------------------------------------------
// Reset values and codes
// ----------------------------------------------------------------
`define RWS_RST_PER     3'h4
`define RWS_RST_WIN     1'b0
`define RWS_RST_SRP     1'b1
`define RWS_RST_UVSEL   2'h0
`define RWS_SOFT_CMD    2'h3
`define RWS_SAT_CFG2    2'h1
`define RWS_SAT_OTHER   2'h2
`define RWS_CLOSED_NUM  6
`define RWS_CLOSED_DEN  10
// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define RWS_CLK_KHZ     100000
`define RWS_LW_MS       200
`define RWS_RF_US       10
`define RWS_RD_US       10000
`endif

// [verilog/rwsup_pkg.sv]
// Types shared by the reset and watchdog supervisor.
// Assumes the map header for all numeric values except the enum encodings.
package rwsup_pkg;
  // Operating mode reported by the surrounding mode logic
  typedef enum logic [2:0] {
    M_INIT = 3'h0, M_NORMAL = 3'h1, M_STOP = 3'h2, M_SLEEP = 3'h3,
    M_RESTART = 3'h4, M_FAILSAFE = 3'h5, M_DEV = 3'h6
  } rwsup_mode_t;
  // Reset output sequence, Gray coded along the loop
  typedef enum logic [1:0] {
    RS_HIGH = 2'h0, RS_FILTER = 2'h1, RS_LOW = 2'h3, RS_DELAY = 2'h2
  } rwsup_rst_t;
  // Watchdog window state, Gray coded along the loop
  typedef enum logic [1:0] {
    WD_OFF = 2'h0, WD_LONG = 2'h1, WD_CLOSED = 2'h3, WD_OPEN = 2'h2
  } rwsup_wd_t;
  // Watchdog configuration held in the watchdog config register
  typedef struct packed {
    logic [2:0] period_select;
    logic       window_mode_select;
  } rwsup_wdcfg_t;
endpackage

// [verilog/rwsup_top.sv]
// Reset output sequencer and watchdog of the supervisor block.
// Assumes synchronous inputs, core_clk at 100 MHz, and an outer mode
// machine that follows the soft reset, restart and normal requests.
//
// Summary of operation
// - Reset event drives reset low after filter, holds it plus delay time.
// - Reset starts low at power-up; released after regulator rise plus delay.
// - Watchdog failure asserts the reset output like undervoltage.
// - Undervoltage threshold is software selectable; lowest one after reset.
// - Reset pulled low only with regulator at least 1 V and supply above POR.
// - Writing 11 to mode field returns to Init and restores all registers.
// - A config bit chooses whether soft reset pulses reset; default yes.
// - Soft reset command is ignored outside Normal and Stop.
// - Window select bit picks time-out or window watchdog; time-out default.
// - Watchdog setup changes only in Normal; frozen in Stop, may switch off.
// - Init starts long window after release; Sleep and Restart keep it off.
// - A new timing write restarts the watchdog with that timing.
// - Watchdog served by a valid write to its config register.
// - Long open window of 200 ms accepts any trigger.
// - Seven periods from 10 to 1000 ms, for both watchdog types.
// - Watchdog reset requests Restart or Fail-Safe and updates fail count.
// - After watchdog reset release, long window starts and Normal is requested.
// - Development mode disables the watchdog entirely.
// - Closed-window trigger or expiry increments the fail count.
// - Fail count saturates at 01 for config 2, else at 10.
// - Fail count clears on good trigger, Sleep, Stop-off, non-watchdog Fail-Safe.
// - Time-out mode: trigger anywhere restarts period; expiry resets.
// - Window mode: closed 60 percent then open; closed trigger or expiry resets.
// - Watchdog writes need even parity over 8 bits, else rejected with error.
//
// Chosen here: strobed register access and the register addresses.
`timescale 1ns/1ps
`include "rwsup_map.svh"

module rwsup_top #(
  parameter int TICK_CYC = `RWS_CLK_KHZ,
  parameter int RF_CYC   = `RWS_RF_US * (`RWS_CLK_KHZ / 1000),
  parameter int RD_CYC   = `RWS_RD_US * (`RWS_CLK_KHZ / 1000)
) (
  // Clock and reset
  input  wire logic               core_clk,
  input  wire logic               rst,
  // Register port
  input  wire logic [7:0]         reg_addr,
  input  wire logic [7:0]         reg_wdata,
  input  wire logic               reg_wr,
  input  wire logic               reg_rd,
  output logic [7:0]              reg_rdata,
  // Supply monitors
  input  wire logic               vcc1_uv,
  input  wire logic               vcc1_above_rise,
  input  wire logic               vcc1_ge_1v,
  input  wire logic               vs_above_por,
  output logic [1:0]              uv_threshold_sel,
  // Mode machine
  input  wire rwsup_pkg::rwsup_mode_t sbc_mode,
  input  wire logic [1:0]         cfg_sel,
  output logic                    soft_reset_req,
  output logic                    wd_reset_req,
  output logic                    wd_goto_failsafe,
  output logic                    auto_normal_req,
  // Open-drain reset pin
  output logic                    reset_out_n_o,
  output logic                    reset_out_n_oe
);

  // ----------------------------------------------------------------
  // Functions
  // ----------------------------------------------------------------
  // Period in ms per code; code 0 falls back to the shortest period
  function automatic logic [10:0] per_ms(input logic [2:0] code);
    unique case (code)
      3'h2: per_ms = 11'h014;
      3'h3: per_ms = 11'h032;
      3'h4: per_ms = 11'h064;
      3'h5: per_ms = 11'h0c8;
      3'h6: per_ms = 11'h1f4;
      3'h7: per_ms = 11'h3e8;
      default: per_ms = 11'h00a;
    endcase
  endfunction

  function automatic logic [10:0] closed_ms(input logic [2:0] code);
    closed_ms = 11'((22'(per_ms(code)) * `RWS_CLOSED_NUM) / `RWS_CLOSED_DEN);
  endfunction

  // ----------------------------------------------------------------
  // Registers and decode
  // ----------------------------------------------------------------
  rwsup_pkg::rwsup_wdcfg_t wdcfg_q;
  rwsup_pkg::rwsup_rst_t   rs_q;
  rwsup_pkg::rwsup_wd_t    wd_q, wd_d;
  rwsup_pkg::rwsup_mode_t  mode_prev_q;
  logic        srp_q, stopoff_q, err_q, por_q, pend_q, wait_q, cause_q;
  logic [1:0]  uvsel_q, fcnt_q, fcnt_inc, fsat;
  logic [31:0] rcnt_q, tcnt_q;
  logic [10:0] ms_q, ms_d;
  logic        wr_wd, par_ok, trig_ok, soft_ev, ev, released;
  logic        ms_tick, fail_ev, ok_ev, start_long, wd_off, norm_entry;
  logic        is_norm, is_stop;

  assign is_norm = (sbc_mode == rwsup_pkg::M_NORMAL);
  assign is_stop = (sbc_mode == rwsup_pkg::M_STOP);
  assign wr_wd   = reg_wr && (reg_addr == `RWS_OFS_WDCFG);
  assign par_ok  = ~^reg_wdata;
  // Triggers count in the modes where the watchdog can be alive
  assign trig_ok = wr_wd && par_ok &&
                   (is_norm || is_stop || sbc_mode == rwsup_pkg::M_INIT);
  assign soft_ev = reg_wr && (reg_addr == `RWS_OFS_MODE) &&
                   (reg_wdata[1:0] == `RWS_SOFT_CMD) && (is_norm || is_stop);

  // Software-visible configuration; soft reset restores defaults
  always_ff @(posedge core_clk) begin
    if (rst || soft_ev) begin
      wdcfg_q   <= '{period_select: `RWS_RST_PER, window_mode_select: `RWS_RST_WIN};
      srp_q     <= `RWS_RST_SRP;
      uvsel_q   <= `RWS_RST_UVSEL;
      stopoff_q <= 1'b0;
    end else begin
      if (trig_ok && is_norm) begin
        wdcfg_q.period_select      <= reg_wdata[`RWS_WD_PER_LSB +: 3];
        wdcfg_q.window_mode_select <= reg_wdata[`RWS_WINDOW_MODE_SELECT_BIT];
      end
      if (reg_wr && reg_addr == `RWS_OFS_MODE) begin
        srp_q <= reg_wdata[`RWS_MODE_SRP];
      end
      if (reg_wr && reg_addr == `RWS_OFS_CFG) begin
        uvsel_q <= reg_wdata[1:0];
      end
      // Stop-mode disable is armed only from Normal, dropped on re-enable
      if (reg_wr && reg_addr == `RWS_OFS_CFG && is_norm) begin
        stopoff_q <= reg_wdata[`RWS_CFG_STOPOFF];
      end else if (norm_entry || (is_stop && trig_ok)) begin
        stopoff_q <= 1'b0;
      end
    end
  end

  // Serial error flag: parity failure sets, write one clears, set wins
  always_ff @(posedge core_clk) begin
    if (rst || soft_ev) begin
      err_q <= 1'b0;
    end else if (wr_wd && !par_ok) begin
      err_q <= 1'b1;
    end else if (reg_wr && reg_addr == `RWS_OFS_STAT && reg_wdata[`RWS_STAT_ERR]) begin
      err_q <= 1'b0;
    end
  end

  // Read data stand one cycle after the strobe; unmapped reads zero
  always_ff @(posedge core_clk) begin
    if (rst) begin
      reg_rdata <= 8'h00;
    end else if (reg_rd) begin
      unique case (reg_addr)
        `RWS_OFS_WDCFG: reg_rdata <= {wdcfg_q.period_select,
                                      wdcfg_q.window_mode_select, 4'h0};
        `RWS_OFS_MODE:  reg_rdata <= {5'h00, srp_q, 2'h0};
        `RWS_OFS_CFG:   reg_rdata <= {5'h00, stopoff_q, uvsel_q};
        `RWS_OFS_STAT:  reg_rdata <= {2'h0, wd_q, rs_q != rwsup_pkg::RS_HIGH,
                                      err_q, fcnt_q};
        default:        reg_rdata <= 8'h00;
      endcase
    end else begin
      reg_rdata <= 8'h00;
    end
  end

  assign uv_threshold_sel = uvsel_q;

  // ----------------------------------------------------------------
  // Reset output sequencer
  // ----------------------------------------------------------------
  // Power-up hold lasts until the regulator passes its rising threshold
  always_ff @(posedge core_clk) begin
    if (rst) begin
      por_q <= 1'b1;
    end else if (vcc1_above_rise) begin
      por_q <= 1'b0;
    end
  end

  // Pulse events are stretched until the output has gone low; set wins
  always_ff @(posedge core_clk) begin
    if (rst) begin
      pend_q <= 1'b0;
    end else if (fail_ev || (soft_ev && srp_q)) begin
      pend_q <= 1'b1;
    end else if (rs_q == rwsup_pkg::RS_LOW) begin
      pend_q <= 1'b0;
    end
  end

  assign ev       = vcc1_uv || pend_q || por_q;
  assign released = (rs_q == rwsup_pkg::RS_DELAY) && !ev &&
                    (rcnt_q == 32'(RD_CYC - 1));

  // Filter, hold while the cause stands, then the delay time
  always_ff @(posedge core_clk) begin
    if (rst) begin
      rs_q   <= rwsup_pkg::RS_LOW;
      rcnt_q <= 32'h0000_0000;
    end else begin
      unique case (rs_q)
        rwsup_pkg::RS_HIGH: begin
          rcnt_q <= 32'h0000_0000;
          if (ev) begin
            rs_q <= rwsup_pkg::RS_FILTER;
          end
        end
        rwsup_pkg::RS_FILTER: begin
          rcnt_q <= rcnt_q + 32'h0000_0001;
          if (!ev) begin
            rs_q <= rwsup_pkg::RS_HIGH;
          end else if (rcnt_q == 32'(RF_CYC - 1)) begin
            rs_q <= rwsup_pkg::RS_LOW;
          end
        end
        rwsup_pkg::RS_LOW: begin
          rcnt_q <= 32'h0000_0000;
          if (!ev) begin
            rs_q <= rwsup_pkg::RS_DELAY;
          end
        end
        rwsup_pkg::RS_DELAY: begin
          rcnt_q <= rcnt_q + 32'h0000_0001;
          if (ev) begin
            rs_q   <= rwsup_pkg::RS_LOW;
            rcnt_q <= 32'h0000_0000;
          end else if (released) begin
            rs_q <= rwsup_pkg::RS_HIGH;
          end
        end
      endcase
    end
  end

  // The driver can only sink with enough regulator and supply voltage
  assign reset_out_n_o  = 1'b0;
  assign reset_out_n_oe = (rs_q == rwsup_pkg::RS_LOW || rs_q == rwsup_pkg::RS_DELAY) &&
                          vcc1_ge_1v && vs_above_por;

  // ----------------------------------------------------------------
  // Watchdog timer
  // ----------------------------------------------------------------
  // Millisecond timebase, realigned on every change of window state and every good trigger
  always_ff @(posedge core_clk) begin
    if (rst || wd_d != wd_q || ok_ev) begin
      tcnt_q <= 32'h0000_0000;
    end else if (ms_tick) begin
      tcnt_q <= 32'h0000_0000;
    end else begin
      tcnt_q <= tcnt_q + 32'h0000_0001;
    end
  end
  assign ms_tick = (tcnt_q == 32'(TICK_CYC - 1));

  assign norm_entry = is_norm && (mode_prev_q == rwsup_pkg::M_STOP ||
                      mode_prev_q == rwsup_pkg::M_SLEEP ||
                      mode_prev_q == rwsup_pkg::M_RESTART);
  assign start_long = norm_entry ||
                      (released && (sbc_mode == rwsup_pkg::M_INIT || wait_q)) ||
                      (is_stop && stopoff_q && trig_ok);
  assign wd_off = (sbc_mode == rwsup_pkg::M_DEV) || (sbc_mode == rwsup_pkg::M_SLEEP) ||
                  (sbc_mode == rwsup_pkg::M_RESTART) ||
                  (sbc_mode == rwsup_pkg::M_FAILSAFE) ||
                  (is_stop && stopoff_q);

  // Next window state, judging triggers and expiry
  always_comb begin
    wd_d    = wd_q;
    ms_d    = ms_q;
    fail_ev = 1'b0;
    ok_ev   = 1'b0;
    if (start_long) begin
      wd_d = rwsup_pkg::WD_LONG;
      ms_d = 11'h000;
    end else if (wd_off) begin
      wd_d = rwsup_pkg::WD_OFF;
    end else if (trig_ok && wd_q != rwsup_pkg::WD_OFF) begin
      ms_d = 11'h000;
      if (wd_q == rwsup_pkg::WD_CLOSED) begin
        fail_ev = 1'b1;
        wd_d    = rwsup_pkg::WD_OFF;
      end else begin
        ok_ev = 1'b1;
        // Settings written with the trigger take hold at once
        if (is_norm ? reg_wdata[`RWS_WINDOW_MODE_SELECT_BIT] : wdcfg_q.window_mode_select) begin
          wd_d = rwsup_pkg::WD_CLOSED;
        end else begin
          wd_d = rwsup_pkg::WD_OPEN;
        end
      end
    end else if (ms_tick && wd_q != rwsup_pkg::WD_OFF) begin
      ms_d = ms_q + 11'h001;
      unique case (wd_q)
        rwsup_pkg::WD_LONG: begin
          if (ms_d == 11'(`RWS_LW_MS)) begin
            fail_ev = 1'b1;
          end
        end
        rwsup_pkg::WD_CLOSED: begin
          if (ms_d == closed_ms(wdcfg_q.period_select)) begin
            wd_d = rwsup_pkg::WD_OPEN;
          end
        end
        default: begin
          if (ms_d == per_ms(wdcfg_q.period_select)) begin
            fail_ev = 1'b1;
          end
        end
      endcase
      if (fail_ev) begin
        wd_d = rwsup_pkg::WD_OFF;
      end
    end
  end

  // Window state and elapsed time
  always_ff @(posedge core_clk) begin
    if (rst || soft_ev) begin
      wd_q <= rwsup_pkg::WD_OFF;
      ms_q <= 11'h000;
    end else begin
      wd_q <= wd_d;
      ms_q <= ms_d;
    end
  end

  // Previous mode, used to spot entries into Normal
  always_ff @(posedge core_clk) begin
    if (rst) begin
      mode_prev_q <= rwsup_pkg::M_INIT;
    end else begin
      mode_prev_q <= sbc_mode;
    end
  end

  // Waiting for the reset release that follows a watchdog failure
  always_ff @(posedge core_clk) begin
    if (rst || soft_ev) begin
      wait_q <= 1'b0;
    end else if (fail_ev) begin
      wait_q <= 1'b1;
    end else if (released) begin
      wait_q <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Failure count and mode requests
  // ----------------------------------------------------------------
  assign fsat     = (cfg_sel == 2'h1) ? `RWS_SAT_CFG2 : `RWS_SAT_OTHER;
  assign fcnt_inc = (fcnt_q >= fsat) ? fsat : fcnt_q + 2'h1;

  // A new failure outranks every clear in the same cycle except a soft reset
  always_ff @(posedge core_clk) begin
    if (rst || soft_ev) begin
      fcnt_q  <= 2'h0;
      cause_q <= 1'b0;
    end else if (fail_ev) begin
      fcnt_q  <= fcnt_inc;
      cause_q <= 1'b1;
    end else if (ok_ev || sbc_mode == rwsup_pkg::M_SLEEP || (is_stop && stopoff_q) ||
                 (sbc_mode == rwsup_pkg::M_FAILSAFE && !cause_q)) begin
      fcnt_q  <= 2'h0;
      cause_q <= 1'b0;
    end else if (is_norm) begin
      cause_q <= 1'b0;
    end
  end

  // Registered one-cycle requests to the mode machine
  always_ff @(posedge core_clk) begin
    if (rst) begin
      soft_reset_req   <= 1'b0;
      wd_reset_req     <= 1'b0;
      wd_goto_failsafe <= 1'b0;
      auto_normal_req  <= 1'b0;
    end else begin
      soft_reset_req   <= soft_ev;
      wd_reset_req     <= fail_ev;
      wd_goto_failsafe <= fail_ev && (cfg_sel == 2'h0 ||
                          (cfg_sel[1] && fcnt_inc == `RWS_SAT_OTHER));
      auto_normal_req  <= released && wait_q;
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);

  a_cfg_freeze_normal:
    assert property ($changed(wdcfg_q) |-> $past(is_norm) || $past(soft_ev))
    else $error("watchdog config changed outside Normal");
  a_fail_cnt_sat:
    assert property (cfg_sel == 2'h1 && $stable(cfg_sel) |-> fcnt_q <= `RWS_SAT_CFG2 ||
                     $past(fcnt_q) > `RWS_SAT_CFG2 || $past(cfg_sel) != 2'h1)
    else $error("fail count beyond saturation");
  a_parity_reject:
    assert property (wr_wd && !par_ok |=> err_q && $stable(wdcfg_q) && !$past(ok_ev))
    else $error("bad parity write not rejected");
  a_ok_clears_cnt:
    assert property (ok_ev && !soft_ev |=> fcnt_q == 2'h0 && wd_q != rwsup_pkg::WD_OFF)
    else $error("good trigger did not clear fail count");
  a_oe_supply_gate:
    assert property (reset_out_n_oe |-> vcc1_ge_1v && vs_above_por)
    else $error("reset driven without supply");
  a_dev_no_fail:
    assert property (sbc_mode == rwsup_pkg::M_DEV |-> !fail_ev ##1 !wd_reset_req)
    else $error("watchdog failure in development mode");
  a_soft_ignored:
    assert property (reg_wr && reg_addr == `RWS_OFS_MODE && !is_norm && !is_stop
                     |=> !soft_reset_req)
    else $error("soft reset taken outside Normal or Stop");
  a_por_hold_low:
    assert property (por_q |-> rs_q == rwsup_pkg::RS_LOW || rs_q == rwsup_pkg::RS_DELAY)
    else $error("reset released before regulator rise");
  a_filter_time:
    assert property (rs_q == rwsup_pkg::RS_LOW && $past(rs_q) == rwsup_pkg::RS_FILTER
                     |-> $past(rcnt_q) == 32'(RF_CYC - 1))
    else $error("reset asserted before filter time");
  a_closed_trigger:
    assert property (wd_q == rwsup_pkg::WD_CLOSED && trig_ok && !start_long && !wd_off
                     |-> fail_ev ##1 wd_reset_req)
    else $error("closed window trigger not punished");

  c_trigger_failure_count: cover property (fail_ev ##[1:300] released);
  c_soft_reset: cover property (soft_ev && srp_q);
  c_window_ok: cover property (wd_q == rwsup_pkg::WD_OPEN && trig_ok &&
                               wdcfg_q.window_mode_select);

endmodule

// [dv/rwsup_mcu.sv]
// Microcontroller model: serves the supervisor over the register port
// and watches the open-drain reset pin through its pull-up.
`timescale 1ns/1ps
module rwsup_mcu (
  // Clock
  input  wire logic       core_clk,
  // Register port, master side
  output logic [7:0]      reg_addr,
  output logic [7:0]      reg_wdata,
  output logic            reg_wr,
  output logic            reg_rd,
  // Reset pin as seen by the controller
  input  wire logic       reset_out_n_o,
  input  wire logic       reset_out_n_oe,
  output logic            reset_level
);
  // Pull-up wins whenever the device lets go of the pin
  assign reset_level = reset_out_n_oe ? reset_out_n_o : 1'b1;
  initial begin
    reg_addr  = 8'h00;
    reg_wdata = 8'h00;
    reg_wr    = 1'b0;
    reg_rd    = 1'b0;
  end
  // Fix bit 0 so that all eight data bits have even parity
  function automatic logic [7:0] par(input logic [7:0] d);
    return {d[7:1], ^d[7:1]};
  endfunction
  // One-cycle write; the strobe stands for chip select rising
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge core_clk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge core_clk);
    reg_wr    <= 1'b0;
  endtask
  // One-cycle read; data is picked up by the bench monitor
  task automatic rd(input logic [7:0] a);
    @(posedge core_clk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge core_clk);
    reg_rd   <= 1'b0;
  endtask
endmodule

// [dv/rwsup_tb.sv]
// Self-checking bench of the supervisor; reads are checked by a monitor
// against a queue of expected values. Assumes the partner model above.
`timescale 1ns/1ps
module rwsup_tb;
  logic                  core_clk = 1'b0;
  logic                  rst = 1'b1;
  logic [7:0]            reg_addr, reg_wdata, reg_rdata;
  logic                  reg_wr, reg_rd, pin, pend = 1'b0, vcc1_uv = 1'b0;
  logic                  srq, wrq, oe, od, gfs, anr;
  logic                  rise = 1'b0, ge1v = 1'b1, vsok = 1'b1;
  logic [1:0]            cfg = 2'h0, uvs;
  logic [15:0]           e;
  rwsup_pkg::rwsup_mode_t mode = rwsup_pkg::M_INIT;
  logic [15:0]           expq[$];
  logic [31:0]           seed = 32'h96b6;
  logic [7:0]            d;
  int                    err_count = 0, checks_done = 0, soft_cnt = 0, low_cnt = 0, n;
  always #5 core_clk = ~core_clk;
  rwsup_top #(.TICK_CYC(10), .RF_CYC(4), .RD_CYC(20)) dut (.core_clk(core_clk), .rst(rst),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .vcc1_uv(vcc1_uv), .vcc1_above_rise(rise), .vcc1_ge_1v(ge1v),
    .vs_above_por(vsok), .uv_threshold_sel(uvs), .sbc_mode(mode), .cfg_sel(cfg),
    .soft_reset_req(srq), .wd_reset_req(wrq), .wd_goto_failsafe(gfs), .auto_normal_req(anr),
    .reset_out_n_o(od), .reset_out_n_oe(oe));
  rwsup_mcu u_mcu (.core_clk(core_clk), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reset_out_n_o(od), .reset_out_n_oe(oe),
    .reset_level(pin));
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checks_done++;
    if (got !== exp) begin
      err_count++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  // Xorshift step for the random stimulus
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] t;
    t = s ^ (s << 13);
    t = t ^ (t >> 17);
    return t ^ (t << 5);
  endfunction
  // Expected word is {mask, value}; masked bits are compared only
  task automatic rd(input logic [7:0] a, input logic [7:0] m, input logic [7:0] v);
    expq.push_back({m, v});
    u_mcu.rd(a);
  endtask
  // Read data stands only in the cycle after the strobe
  always @(posedge core_clk) begin
    if (pend) begin
      e = expq.pop_front();
      chk(reg_rdata & e[15:8], e[7:0] & e[15:8]);
    end
    pend <= reg_rd;
    if (srq === 1'b1) soft_cnt++;
    if (pin === 1'b0) low_cnt++;
  end
  task automatic results;
    $display("checks %0d errors %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  // Hang guard, well beyond the longest expected sequence
  initial begin
    #400us;
    err_count++;
    results();
  end
  initial begin
    repeat (20) @(posedge core_clk);
    rst <= 1'b0;
    repeat (2) @(posedge core_clk);
    chk({7'h0, pin}, 8'h00);
    repeat (30) @(posedge core_clk);
    chk({7'h0, pin}, 8'h00);
    // Regulator passes its rising threshold: release after the delay
    rise <= 1'b1;
    repeat (30) @(posedge core_clk);
    chk({7'h0, pin}, 8'h01);
    rd(8'h00, 8'hff, 8'h80);
    rd(8'h04, 8'hff, 8'h04);
    rd(8'h08, 8'hff, 8'h00);
    rd(8'h40, 8'hff, 8'h00);
    u_mcu.wr(8'h08, 8'h02);
    @(posedge core_clk);
    chk({6'h00, uvs}, 8'h02);
    // Bad parity in INIT: flag set, nothing else moves
    u_mcu.wr(8'h00, 8'h20);
    rd(8'h0c, 8'h3f, 8'h14);
    rd(8'h00, 8'hff, 8'h80);
    u_mcu.wr(8'h0c, 8'h04);
    // Soft reset is accepted only in Normal and Stop
    for (int i = 0; i < 7; i++) begin
      mode <= rwsup_pkg::rwsup_mode_t'(i[2:0]);
      soft_cnt = 0;
      low_cnt  = 0;
      u_mcu.wr(8'h04, 8'h03);
      repeat (40) @(posedge core_clk);
      chk(soft_cnt[7:0], (i == 1 || i == 2) ? 8'h01 : 8'h00);
      // The Init write cleared the pulse bit, the Normal soft reset set it again
      chk(8'(low_cnt != 0), (i == 2) ? 8'h01 : 8'h00);
    end
    chk({6'h00, uvs}, 8'h00);
    // Leaving Restart for Normal opens a long window
    mode <= rwsup_pkg::M_RESTART;
    @(posedge core_clk);
    mode <= rwsup_pkg::M_NORMAL;
    rd(8'h0c, 8'h30, 8'h10);
    // Short undervoltage dip: low after filter, high after delay
    vcc1_uv <= 1'b1;
    repeat (8) @(posedge core_clk);
    chk({7'h0, pin}, 8'h00);
    vcc1_uv <= 1'b0;
    repeat (30) @(posedge core_clk);
    chk({7'h0, pin}, 8'h01);
    // Random setup in Normal is kept exactly as written
    seed = xs(seed);
    d = u_mcu.par({(seed[7:5] == 3'h0) ? 3'h1 : seed[7:5], 5'h00});
    u_mcu.wr(8'h00, d);
    rd(8'h00, 8'hff, {d[7:5], 5'h00});
    // Shortest time-out period: fail after 100 cycles, no trigger
    u_mcu.wr(8'h00, u_mcu.par(8'h20));
    n = 0;
    while (wrq !== 1'b1 && n < 300) begin
      @(posedge core_clk);
      n++;
    end
    chk(8'(n > 96 && n < 104), 8'h01);
    chk({7'h0, gfs}, 8'h01);
    repeat (12) @(posedge core_clk);
    chk({7'h0, pin}, 8'h00);
    // Supply too low to sink: the pull-up shows through
    ge1v <= 1'b0;
    @(posedge core_clk);
    chk({7'h0, pin}, 8'h01);
    ge1v <= 1'b1;
    vsok <= 1'b0;
    @(posedge core_clk);
    chk({7'h0, pin}, 8'h01);
    vsok <= 1'b1;
    rd(8'h0c, 8'h03, 8'h01);
    // Release after the failure asks for Normal and opens a long window
    n = 0;
    while (anr !== 1'b1 && n < 60) begin
      @(posedge core_clk);
      n++;
    end
    chk(8'(n < 60), 8'h01);
    rd(8'h0c, 8'h30, 8'h10);
    // Window mode, shortest period: an open-part trigger is good,
    // an immediate second one hits the closed part
    cfg <= 2'h1;
    u_mcu.wr(8'h00, 8'h30);
    rd(8'h0c, 8'h33, 8'h30);
    repeat (70) @(posedge core_clk);
    u_mcu.wr(8'h00, 8'h30);
    u_mcu.wr(8'h00, 8'h30);
    n = 0;
    while (wrq !== 1'b1 && n < 10) begin
      @(posedge core_clk);
      n++;
    end
    chk(8'(n < 4), 8'h01);
    chk({7'h0, gfs}, 8'h00);
    rd(8'h0c, 8'h03, 8'h01);
    // Let the monitor take the last read data
    repeat (2) @(posedge core_clk);
    results();
  end
endmodule
